/* File: common/ifp_pkg.sv */
// Constants, field layout and channel states for the injector fault protection block.
package ifp_pkg;
    localparam int          CLK_NS      = 5;
    localparam int          LIMIT_US    = 60;
    localparam int          RETRY_MS    = 10;
    localparam int          RETRY_US    = RETRY_MS * 1000;
    localparam int          CAL_US      = 32;
    localparam int          CAL_SHIFT   = $clog2(CAL_US);
    localparam logic [10:0] TICK_NOM    = 11'(1000 / CLK_NS);
    localparam int          NCH         = 4;
    localparam int          FRAME_BITS  = 16;
    localparam logic [4:0]  FRAME_LEN   = 5'h10;
    localparam logic [3:0]  CMD_FAULT   = 4'h2;
    localparam logic [3:0]  CMD_ONOFF   = 4'h3;
    localparam logic [3:0]  CMD_CAL     = 4'hE;
    localparam logic [11:0] CFG_RST     = 12'h80F;
    localparam logic [3:0]  ONOFF_RST   = 4'h0;
    localparam int          CFG_RETRY_B = 11;
    localparam int          CFG_TLIM_B  = 10;
    localparam int          CFG_TMR_B   = 9;
    localparam int          CFG_OFF_LSB = 0;
    localparam int          CFG_ON_LSB  = 4;
    localparam int          ST_SUP_LSB  = 12;
    localparam int          ST_OT_LSB   = 8;
    localparam int          ST_ON_LSB   = 4;
    localparam int          ST_OFF_LSB  = 0;
    localparam int          SYNC_W      = 24;

    typedef enum logic [2:0] {
        CH_IDLE,
        CH_RUN,
        CH_LIMIT,
        CH_RETRY,
        CH_HOT,
        CH_LATCH
    } ifp_ch_e;
endpackage : ifp_pkg

/* File: src/ifp_tbase.sv */
// Calibrated one-microsecond time base trimmed by the chip select low pulse.
`timescale 1ns/1ps
`default_nettype none
module ifp_tbase (
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic srst,
    // Calibration control.
    input  wire logic cs_low,
    input  wire logic cal_arm,
    // Time base.
    output var  logic tick
);
    import ifp_pkg::*;

    logic        armed_r;
    logic        meas_r;
    logic        cs_d_r;
    logic [15:0] mcnt_r;
    logic [10:0] per_r;
    logic [10:0] tcnt_r;
    logic        tick_r;

    wire         low_start = cs_low & ~cs_d_r;
    wire         low_end   = ~cs_low & cs_d_r;
    wire  [10:0] meas_per  = mcnt_r[CAL_SHIFT +: 11];
    wire         tc_end    = (tcnt_r >= per_r - 11'h001);

    // The low pulse is CAL_US long, so its cycle count over CAL_US is cycles per tick.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            armed_r <= 1'b0;
            meas_r  <= 1'b0;
            cs_d_r  <= 1'b0;
            mcnt_r  <= 16'h0000;
            per_r   <= TICK_NOM;
        end else begin
            cs_d_r <= cs_low;
            if (cal_arm) begin
                armed_r <= 1'b1;
            end else if (armed_r && low_start) begin
                armed_r <= 1'b0;
                meas_r  <= 1'b1;
                mcnt_r  <= 16'h0001;
            end
            if (meas_r && cs_low && mcnt_r != 16'hFFFF) begin
                mcnt_r <= mcnt_r + 16'h0001;
            end
            if (meas_r && low_end) begin
                meas_r <= 1'b0;
                if (meas_per != 11'h000) begin
                    per_r <= meas_per;
                end
            end
        end
    end

    // Every protection timer counts these ticks.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tcnt_r <= 11'h000;
            tick_r <= 1'b0;
        end else begin
            tcnt_r <= tc_end ? 11'h000 : tcnt_r + 11'h001;
            tick_r <= tc_end;
        end
    end

    assign tick = tick_r;
endmodule : ifp_tbase
`default_nettype wire

/* File: src/ifp_top.sv */
// Fault protection, open-load diagnostics and serial control for four injector drivers.
`timescale 1ns/1ps
`default_nettype none
module ifp_top #(
    parameter logic [15:0] LIMIT_TICKS = 16'(ifp_pkg::LIMIT_US),
    parameter logic [15:0] RETRY_TICKS = 16'(ifp_pkg::RETRY_US)
) (
    // Clock and reset.
    input  wire logic                     ref_clk,
    input  wire logic                     srst,
    // Serial interface.
    input  wire logic                     spi_cs_n,
    input  wire logic                     spi_sclk,
    input  wire logic                     spi_mosi,
    output var  logic                     spi_miso,
    output var  logic                     spi_miso_oe_n,
    // Output requests.
    input  wire logic [ifp_pkg::NCH-1:0]  parallel_drive_in_n,
    input  wire logic                     output_disable_in,
    // Driver sense inputs.
    input  wire logic [ifp_pkg::NCH-1:0]  cur_limit_in,
    input  wire logic [ifp_pkg::NCH-1:0]  over_temp_in,
    input  wire logic [ifp_pkg::NCH-1:0]  drain_low_in,
    input  wire logic [ifp_pkg::NCH-1:0]  on_current_low_in,
    // Driver controls.
    output var  logic [ifp_pkg::NCH-1:0]  injector_output_n,
    output var  logic [ifp_pkg::NCH-1:0]  off_sink_en
);
    import ifp_pkg::*;

    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic              cs_d_r;
    logic              sclk_d_r;
    logic [15:0]       shin_r;
    logic [15:0]       shout_r;
    logic [4:0]        bcnt_r;
    logic              miso_r;
    logic              miso_oe_n_r;
    logic [11:0]       cfg_r;
    logic [NCH-1:0]    on_spi_r;
    logic              cal_arm_r;
    logic [15:0]       stat_r;
    logic [NCH-1:0]    out_r;
    logic [NCH-1:0]    sink_r;
    ifp_ch_e           st_r   [NCH];
    ifp_ch_e           st_nxt [NCH];
    logic [15:0]       tcnt_r [NCH];
    logic [NCH-1:0]    clr;
    logic [NCH-1:0]    on_nxt;
    logic              tick;

    // Every pin input except ref_clk and srst passes two flip-flops before use.
    wire [SYNC_W-1:0] sync_in = {spi_cs_n, spi_sclk, spi_mosi,
                                 output_disable_in, parallel_drive_in_n,
                                 cur_limit_in, over_temp_in,
                                 drain_low_in, on_current_low_in};

    wire           cs_s   = sync2_r[23];
    wire           sclk_s = sync2_r[22];
    wire           mosi_s = sync2_r[21];
    wire           dis_s  = sync2_r[20];
    wire [NCH-1:0] din_s  = sync2_r[19:16];
    wire [NCH-1:0] cl_s   = sync2_r[15:12];
    wire [NCH-1:0] ot_s   = sync2_r[11:8];
    wire [NCH-1:0] dl_s   = sync2_r[7:4];
    wire [NCH-1:0] ocl_s  = sync2_r[3:0];

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sync1_r <= {SYNC_W{1'b1}};
            sync2_r <= {SYNC_W{1'b1}};
        end else begin
            sync1_r <= sync_in;
            sync2_r <= sync1_r;
        end
    end

    // Serial framing edges.
    wire       cs_low  = ~cs_s;
    wire       cs_fall = ~cs_s & cs_d_r;
    wire       cs_rise = cs_s & ~cs_d_r;
    wire       sclk_up = cs_low & sclk_s & ~sclk_d_r;
    wire       sclk_dn = cs_low & ~sclk_s & sclk_d_r;
    wire [3:0] addr    = shin_r[15:12];
    wire       apply   = cs_rise & (bcnt_r == FRAME_LEN);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cs_d_r   <= 1'b1;
            sclk_d_r <= 1'b0;
            shin_r   <= 16'h0000;
            bcnt_r   <= 5'h00;
        end else begin
            cs_d_r   <= cs_s;
            sclk_d_r <= sclk_s;
            if (cs_fall) begin
                bcnt_r <= 5'h00;
            end else if (sclk_up) begin
                shin_r <= {shin_r[14:0], mosi_s};
                if (bcnt_r != 5'h1F) begin
                    bcnt_r <= bcnt_r + 5'h01;
                end
            end
        end
    end

    // The status word is captured at the frame start and shifted out MSB first.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            shout_r     <= 16'h0000;
            miso_r      <= 1'b0;
            miso_oe_n_r <= 1'b1;
        end else begin
            miso_oe_n_r <= cs_s;
            if (cs_fall) begin
                shout_r <= stat_r;
                miso_r  <= stat_r[FRAME_BITS-1];
            end else if (sclk_dn) begin
                shout_r <= {shout_r[14:0], 1'b0};
                miso_r  <= shout_r[14];
            end
        end
    end

    // Commands take effect on the chip select rising edge.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cfg_r     <= CFG_RST;
            on_spi_r  <= ONOFF_RST;
            cal_arm_r <= 1'b0;
        end else begin
            cal_arm_r <= apply & (addr == CMD_CAL);
            if (apply && addr == CMD_FAULT) begin
                cfg_r <= shin_r[11:0];
            end
            if (apply && addr == CMD_ONOFF) begin
                on_spi_r <= shin_r[NCH-1:0];
            end
        end
    end

    ifp_tbase u_ifp_tbase (
        .ref_clk (ref_clk),
        .srst    (srst),
        .cs_low  (cs_low),
        .cal_arm (cal_arm_r),
        .tick    (tick)
    );

    // Protection strategy decode.
    wire           retry   = cfg_r[CFG_RETRY_B];
    wire           hot_en  = cfg_r[CFG_TLIM_B];
    wire           tmr_en  = ~cfg_r[CFG_TLIM_B] | cfg_r[CFG_TMR_B];
    wire           both_en = cfg_r[CFG_TLIM_B] & cfg_r[CFG_TMR_B];
    wire [NCH-1:0] dreq    = (on_spi_r | din_s) & {NCH{~dis_s}};

    genvar n;
    generate
        for (n = 0; n < NCH; n++) begin : g_ch
            wire hot_trip = hot_en & ot_s[n];
            wire tmr_trip = tmr_en & (tcnt_r[n] >= LIMIT_TICKS);
            wire ret_done = tcnt_r[n] >= RETRY_TICKS;

            always_comb begin
                st_nxt[n] = st_r[n];
                clr[n]    = 1'b0;
                case (st_r[n])
                    CH_IDLE: begin
                        if (dreq[n]) begin
                            st_nxt[n] = CH_RUN;
                        end
                    end
                    CH_RUN: begin
                        if (cl_s[n]) begin
                            st_nxt[n] = CH_LIMIT;
                            clr[n]    = 1'b1;
                        end
                    end
                    CH_LIMIT: begin
                        if (hot_trip) begin
                            st_nxt[n] = !retry ? CH_LATCH : (tmr_en ? CH_RETRY : CH_HOT);
                            clr[n]    = 1'b1;
                        end else if (tmr_trip) begin
                            st_nxt[n] = retry ? CH_RETRY : CH_LATCH;
                            clr[n]    = 1'b1;
                        end else if (!cl_s[n]) begin
                            st_nxt[n] = CH_RUN;
                        end
                    end
                    CH_RETRY: begin
                        if (ret_done && !(both_en && ot_s[n])) begin
                            st_nxt[n] = CH_RUN;
                        end
                    end
                    CH_HOT: begin
                        if (!ot_s[n]) begin
                            st_nxt[n] = CH_RUN;
                        end
                    end
                    CH_LATCH: begin
                        st_nxt[n] = CH_LATCH;
                    end
                    default: begin
                        st_nxt[n] = CH_IDLE;
                    end
                endcase
                if (!dreq[n]) begin
                    st_nxt[n] = CH_IDLE;
                end
            end

            assign on_nxt[n] = (st_nxt[n] == CH_RUN) | (st_nxt[n] == CH_LIMIT);

            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    st_r[n]   <= CH_IDLE;
                    tcnt_r[n] <= 16'h0000;
                end else begin
                    st_r[n] <= st_nxt[n];
                    if (clr[n]) begin
                        tcnt_r[n] <= 16'h0000;
                    end else if (tick && tcnt_r[n] != 16'hFFFF) begin
                        tcnt_r[n] <= tcnt_r[n] + 16'h0001;
                    end
                end
            end

            a_limit_keeps_on: assert property (
                @(posedge ref_clk) disable iff (srst)
                st_r[n] == CH_LIMIT |-> out_r[n])
                else $error("output not driven in current limit");

            a_timer_trip_off: assert property (
                @(posedge ref_clk) disable iff (srst)
                st_r[n] == CH_LIMIT && tmr_trip && !hot_trip && dreq[n]
                |=> (st_r[n] == CH_RETRY || st_r[n] == CH_LATCH) && !out_r[n])
                else $error("timer expiry did not switch output off");

            a_hot_hold_off: assert property (
                @(posedge ref_clk) disable iff (srst)
                st_r[n] == CH_HOT && ot_s[n] && dreq[n] |=> st_r[n] == CH_HOT)
                else $error("output left thermal shutdown while hot");

            a_retry_wait: assert property (
                @(posedge ref_clk) disable iff (srst)
                st_r[n] == CH_RETRY && !ret_done && dreq[n] |=> !out_r[n])
                else $error("retry began before off period ended");

            a_retry_hot_hold: assert property (
                @(posedge ref_clk) disable iff (srst)
                st_r[n] == CH_RETRY && both_en && ot_s[n] && dreq[n]
                |=> st_r[n] == CH_RETRY)
                else $error("combined mode retried while hot");

            a_latch_stays_off: assert property (
                @(posedge ref_clk) disable iff (srst)
                st_r[n] == CH_LATCH && dreq[n] |=> st_r[n] == CH_LATCH && !out_r[n])
                else $error("latched output turned back on");

            a_off_open_mask: assert property (
                @(posedge ref_clk) disable iff (srst)
                !cfg_r[CFG_OFF_LSB + n] |=> !stat_r[ST_OFF_LSB + n])
                else $error("off open load reported with sink disabled");

            a_on_open_mask: assert property (
                @(posedge ref_clk) disable iff (srst)
                !cfg_r[CFG_ON_LSB + n] |=> !stat_r[ST_ON_LSB + n])
                else $error("on open load reported with detection disabled");

            a_supply_short_flag: assert property (
                @(posedge ref_clk) disable iff (srst)
                dreq[n] && cl_s[n] |=> stat_r[ST_SUP_LSB + n])
                else $error("supply short not reported");
        end
    endgenerate

    // Open-load diagnostics follow the drive state and the enable bits.
    wire [NCH-1:0] off_ol = ~out_r & cfg_r[CFG_OFF_LSB +: NCH] & dl_s;
    wire [NCH-1:0] on_ol  = out_r & cfg_r[CFG_ON_LSB +: NCH] & ocl_s;
    wire [NCH-1:0] short_to_supply = dreq & cl_s;
    wire [15:0]    stat_nxt = {short_to_supply, ot_s, on_ol, off_ol};

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            out_r  <= {NCH{1'b0}};
            sink_r <= {NCH{1'b0}};
            stat_r <= 16'h0000;
        end else begin
            out_r  <= on_nxt;
            sink_r <= cfg_r[CFG_OFF_LSB +: NCH] & ~on_nxt;
            stat_r <= stat_nxt;
        end
    end

    a_disable_forces_off: assert property (
        @(posedge ref_clk) disable iff (srst)
        dis_s |=> out_r == {NCH{1'b0}})
        else $error("output on while disabled");

    a_cfg_on_cs_rise: assert property (
        @(posedge ref_clk) disable iff (srst)
        apply && addr == CMD_FAULT |=> cfg_r == $past(shin_r[11:0]))
        else $error("fault config not applied at frame end");

    a_cfg_held_in_frame: assert property (
        @(posedge ref_clk) disable iff (srst)
        !apply |=> $stable(cfg_r))
        else $error("fault config changed outside frame end");

    assign spi_miso          = miso_r;
    assign spi_miso_oe_n     = miso_oe_n_r;
    assign injector_output_n = out_r;
    assign off_sink_en       = sink_r;
endmodule : ifp_top
`default_nettype wire

/* File: testbench/ifp_host.sv */
// Serial host model that shifts frames into the injector fault protection block.
`timescale 1ns/1ps
`default_nettype none
module ifp_host (
    // Reference clock used to pace the serial lines.
    input  wire logic ref_clk,
    // Serial interface.
    output var  logic spi_cs_n,
    output var  logic spi_sclk,
    output var  logic spi_mosi,
    input  wire logic spi_miso,
    input  wire logic spi_miso_oe_n
);
    // Half of the 160 ns serial clock period, in reference cycles.
    localparam int HALF = 16;
    int            cyc;

    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
        cyc      = 0;
    end

    task automatic half_bit();
        repeat (HALF) @(posedge ref_clk);
        #1;
        cyc += HALF;
    endtask : half_bit

    // Shifts nb bits MSB first and holds chip select low for at least low_cyc cycles.
    task automatic xfer(input logic [15:0] tx, input int nb, input int low_cyc,
                        output logic [15:0] rx);
        rx  = 16'h0000;
        cyc = 0;
        @(posedge ref_clk);
        #1;
        spi_cs_n = 1'b0;
        for (int i = 0; i < nb; i++) begin
            spi_mosi = tx[15-i];
            half_bit();
            rx       = {rx[14:0], spi_miso_oe_n ? 1'bx : spi_miso};
            spi_sclk = 1'b1;
            half_bit();
            spi_sclk = 1'b0;
        end
        half_bit();
        while (cyc < low_cyc) begin
            @(posedge ref_clk);
            #1;
            cyc++;
        end
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        half_bit();
    endtask : xfer
endmodule : ifp_host
`default_nettype wire

/* File: testbench/tb_injector_fault_protection.sv */
// Self-checking bench for the injector fault protection block driven by a serial host.
`timescale 1ns/1ps
`default_nettype none
module tb_injector_fault_protection;
    import ifp_pkg::*;
    localparam int TICK = int'(TICK_NOM);
    localparam int LIM  = 4;
    localparam int RET  = 20;
    logic        ref_clk;
    logic        srst;
    logic        cs_n;
    logic        sclk;
    logic        mosi;
    logic        miso;
    logic        miso_oe_n;
    logic [3:0]  pdrv;
    logic        odis;
    logic [3:0]  clim;
    logic [3:0]  otmp;
    logic [3:0]  dlow;
    logic [3:0]  ocl;
    logic [3:0]  out;
    logic [3:0]  sink;
    logic [15:0] rx;
    int          err_total;
    int          samples_checked;
    logic [3:0]  modes [8] = '{4'h8, 4'hA, 4'hC, 4'hE, 4'h0, 4'h2, 4'h4, 4'h6};
    int          widths [2] = '{6400, 4800};

    ifp_top #(
        .LIMIT_TICKS(16'(LIM)),
        .RETRY_TICKS(16'(RET))
    ) u_ifp_top (
        .ref_clk             (ref_clk),
        .srst                (srst),
        .spi_cs_n            (cs_n),
        .spi_sclk            (sclk),
        .spi_mosi            (mosi),
        .spi_miso            (miso),
        .spi_miso_oe_n       (miso_oe_n),
        .parallel_drive_in_n (pdrv),
        .output_disable_in   (odis),
        .cur_limit_in        (clim),
        .over_temp_in        (otmp),
        .drain_low_in        (dlow),
        .on_current_low_in   (ocl),
        .injector_output_n   (out),
        .off_sink_en         (sink)
    );

    ifp_host u_ifp_host (
        .ref_clk       (ref_clk),
        .spi_cs_n      (cs_n),
        .spi_sclk      (sclk),
        .spi_mosi      (mosi),
        .spi_miso      (miso),
        .spi_miso_oe_n (miso_oe_n)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic inr(input int v, input int lo, input int hi);
        return v >= lo && v <= hi;
    endfunction : inr

    task automatic cw(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cw

    task automatic wr(input logic [15:0] w);
        u_ifp_host.xfer(w, 16, 0, rx);
    endtask : wr

    // Counts cycles until output 0 switches off.
    task automatic trip(output int t);
        t = 0;
        while (out[0] === 1'b1) begin
            if (t == 3000) begin
                err_total++;
                test_done();
            end
            cw(1);
            t++;
        end
    endtask : trip

    task automatic t_onoff();
        wr({CMD_ONOFF, 12'h005});
        cw(5);
        chk(16'(out), 16'h0005);
        chk(16'(sink), 16'h000A);
        u_ifp_host.xfer({CMD_ONOFF, 12'h00F}, 15, 0, rx);
        cw(5);
        chk(16'(out), 16'h0005);
        pdrv = 4'h2;
        cw(5);
        chk(16'(out), 16'h0007);
        odis = 1'b1;
        cw(5);
        chk(16'(out), 16'h0000);
        odis = 1'b0;
        pdrv = 4'h0;
        wr({CMD_ONOFF, 12'h000});
    endtask : t_onoff

    task automatic t_status();
        wr({CMD_FAULT, 12'h824});
        wr({CMD_ONOFF, 12'h003});
        clim = 4'h1;
        dlow = 4'hC;
        ocl  = 4'h2;
        otmp = 4'h8;
        cw(10);
        wr(16'h0000);
        chk(rx, 16'h1824);
        chk(16'(sink), 16'h0004);
        wr({CMD_FAULT, 12'h804});
        wr(16'h0000);
        chk(rx, 16'h1804);
        clim = 4'h0;
        dlow = 4'h0;
        ocl  = 4'h0;
        otmp = 4'h0;
        wr({CMD_ONOFF, 12'h000});
        cw(20);
    endtask : t_status

    task automatic prot(input logic [3:0] nib);
        int t;
        wr({CMD_FAULT, nib, 8'h0F});
        wr({CMD_ONOFF, 12'h001});
        clim = 4'h1;
        cw(300);
        chk(16'(out[0]), 16'h0001);
        if (nib[1] | ~nib[2]) begin
            trip(t);
            chk(16'(inr(t + 300, (LIM - 1) * TICK, LIM * TICK + 20)), 16'h0001);
        end else begin
            cw(1500);
            chk(16'(out[0]), 16'h0001);
        end
        if (nib[2]) begin
            otmp = 4'h1;
            cw(10);
            chk(16'(out[0]), 16'h0000);
        end
        cw(4300);
        chk(16'(out[0]), 16'(nib[3] & ~nib[2]));
        otmp = 4'h0;
        cw(30);
        chk(16'(out[0]), 16'(nib[3]));
        clim = 4'h0;
        wr({CMD_ONOFF, 12'h000});
        cw(20);
    endtask : prot

    // The shorter pulse stands in for an oscillator that has drifted slow.
    task automatic t_cal(input int w);
        int t;
        wr({CMD_CAL, 12'h000});
        fork
            u_ifp_host.xfer({CMD_ONOFF, 12'h001}, 16, w, rx);
            begin
                cw(1000);
                chk(16'(out), 16'h0000);
            end
        join
        cw(10);
        chk(16'(out), 16'h0001);
        wr({CMD_FAULT, 12'h00F});
        clim = 4'h1;
        trip(t);
        chk(16'(inr(t, (LIM - 1) * w / CAL_US, LIM * w / CAL_US + 20)), 16'h0001);
        clim = 4'h0;
        wr({CMD_ONOFF, 12'h000});
        cw(20);
    endtask : t_cal

    initial begin
        err_total       = 0;
        samples_checked = 0;
        srst            = 1'b1;
        pdrv            = 4'h0;
        odis            = 1'b0;
        clim            = 4'h0;
        otmp            = 4'h0;
        dlow            = 4'h0;
        ocl             = 4'h0;
        cw(20);
        srst = 1'b0;
        cw(5);
        chk(16'(out), 16'h0000);
        chk(16'(sink), 16'h000F);
        t_onoff();
        t_status();
        foreach (modes[i]) begin
            prot(modes[i]);
        end
        foreach (widths[i]) begin
            t_cal(widths[i]);
        end
        test_done();
    end
endmodule : tb_injector_fault_protection
`default_nettype wire
